// File: i2cmac_bus_model.sv
// Far side of the shared bus: pull-ups, a second master, a stuck data line.
// Assumes open-drain enables from the block; frame rises once per foreign transfer.
`timescale 1ns/10ps
module i2cmac_bus_model (
    input wire logic sda_oe, scl_oe, hold_sda, frame,
    output logic     sda, scl
);
    logic far_sda = 1'b0, far_scl = 1'b0;  // High while the foreign master pulls low
    // Wired AND with pull-ups; the link clock stands still outside frames
    assign sda = !(sda_oe || far_sda || hold_sda);
    assign scl = !(scl_oe || far_scl);
    // Start, two clocks of 160 ns, then Stop
    always @(posedge frame) begin
        #3 far_sda = 1'b1;
        #80 far_scl = 1'b1;
        repeat (2) begin #80 far_scl = 1'b0; #80 far_scl = 1'b1; end
        #80 far_scl = 1'b0;
        #80 far_sda = 1'b0;
    end
endmodule

// File: i2cmac_pkg.sv
// Package for the two-wire master arbitration and collision block.
// Assumes a 32-bit APB slave port and a 100 MHz system clock.
package i2cmac_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;  // Enable, interrupt enables, sleep
    localparam logic [7:0] OFS_CON2     = 8'h04;  // control_register_two
    localparam logic [7:0] OFS_STATUS   = 8'h08;  // port_status_register
    localparam logic [7:0] OFS_FLAGS    = 8'h0C;  // Sticky flags, write one to clear
    localparam logic [7:0] OFS_RELOAD   = 8'h10;  // reload_value_register
    localparam logic [7:0] OFS_BUFFER   = 8'h14;  // tx_rx_buffer
    localparam logic [7:0] OFS_SLV_ADDR = 8'h18;  // Own slave address
    // Control register fields
    localparam int CTRL_EN   = 0;                 // Port enable
    localparam int CTRL_PIE  = 1;                 // Port interrupt enable
    localparam int CTRL_BIE  = 2;                 // Bus collision interrupt enable
    localparam int CTRL_SLP  = 3;                 // Sleep mode
    // Request bits of control_register_two
    localparam int CON2_SEN  = 0;                 // Start request
    localparam int CON2_RSEN = 1;                 // Repeated start request
    localparam int CON2_PEN  = 2;                 // Stop request
    localparam int CON2_ACKEN= 4;                 // Acknowledge request
    localparam int CON2_ACKDT= 5;                 // Acknowledge data level
    // Status fields
    localparam int STAT_BF   = 0;                 // buffer_full_flag
    localparam int STAT_S    = 3;                 // Start seen
    localparam int STAT_P    = 4;                 // Stop seen
    localparam int STAT_TX   = 2;                 // Master sequence active (any state but idle)
    // Flag fields
    localparam int FLG_PIF   = 0;                 // port_interrupt_flag
    localparam int FLG_BCL   = 1;                 // bus_collision_flag
    localparam int FLG_WRITE_COLLISION_FLAG  = 2;                 // write_collision_flag
    localparam int FLG_WAKE  = 3;                 // Wake request seen
    // Reset values
    localparam logic [7:0] RST_RELOAD   = 8'h4F;
    localparam logic [6:0] RST_SLV_ADDR = 7'h2A;
    // Sequencer states
    typedef enum {
        I2CMAC_IDLE, I2CMAC_ST_WAIT, I2CMAC_ST_HOLD, I2CMAC_RS_SDA, I2CMAC_RS_SCL,
        I2CMAC_RS_HIGH, I2CMAC_RS_HOLD, I2CMAC_SP_LOW, I2CMAC_SP_SCL, I2CMAC_SP_HIGH,
        I2CMAC_AK_LOW, I2CMAC_AK_HIGH, I2CMAC_TX_LOW, I2CMAC_TX_HIGH
    } i2cmac_state_t;
endpackage

// File: i2cmac_properties.sv
// Checker: port-level properties of the collision block.
// Assumes one clock domain; bound to the top by the line at the foot.
`timescale 1ns/10ps
module i2cmac_properties
    import i2cmac_pkg::*;
(
    input wire logic        SYS_CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
    input wire logic        SDA_IN, SCL_IN, SDA_OE, SCL_OE, IRQ,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA, PRDATA
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // Bus slave answers at once; errors and upper bits read zero
    apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
    ready_phase_a: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
    err_zero_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("bad err");
    upper_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper bits");
    // Lines and interrupt stay quiet in reset
    rst_quiet_a: assert property (disable iff (1'b0) !RESET_N |-> !SDA_OE && !SCL_OE && !IRQ)
        else $error("drive in reset");
    irq_hold_a: assert property (IRQ && !PSEL && !$past(PSEL) |=> IRQ)
        else $error("irq dropped");
    start_abort_a: assert property (PSEL && PENABLE && PWRITE && PADDR == OFS_CON2
        && PWDATA[CON2_SEN] && !SDA_OE && !SCL_OE && !SDA_IN && !$past(SDA_IN, 5)
        |=> !SDA_OE [*8]) else $error("start not aborted");
    start_done_a: assert property ($rose(SDA_OE) && !SCL_OE && SCL_IN |-> ##[1:300] SCL_OE)
        else $error("no clock low after start");
    cover property ($rose(SCL_OE) && SDA_OE);
    cover property (PSLVERR);
    cover property ($rose(IRQ));
endmodule
bind i2cmac_top i2cmac_properties u_props (.*);

// File: i2cmac_top.sv
// Master arbitration and collision logic for a two-wire serial port, with APB registers.
// Assumes SDA and SCL pins are open drain, resolved outside; pins are asynchronous.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module i2cmac_top
    import i2cmac_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic             PREADY,
    output logic [31:0]      PRDATA,
    output logic             PSLVERR,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic        SCL_IN,
    output logic             SCL_OUT,
    output logic             SCL_OE,
    output logic             IRQ,
    output logic             WAKE
);
    import i2cmac_pkg::*;

    // Synchronisers for the two pins
    logic [1:0] sda_sync_reg;                       // SDA two-stage sampler
    logic [1:0] scl_sync_reg;                       // SCL two-stage sampler
    logic       sda_prev_reg;                       // Previous settled SDA
    logic       scl_prev_reg;                       // Previous settled SCL
    logic       sda;                                // Settled SDA level
    logic       scl;                                // Settled SCL level
    logic       start_det;                          // Start condition on the bus
    logic       stop_det;                           // Stop condition on the bus

    // Registers
    logic [3:0]  ctrl_reg;                          // Enable, enables, sleep
    logic [5:0]  con2_reg;                          // Request bits
    logic [3:0]  flags_reg;                         // Sticky flags
    logic [7:0]  reload_reg;                        // Baud reload value
    logic [7:0]  buf_reg;                           // tx_rx_buffer
    logic [6:0]  slv_addr_reg;                      // Own slave address
    logic        bf_reg;                            // buffer_full_flag
    logic        s_seen_reg;                        // Start seen
    logic        p_seen_reg;                        // Stop seen
    logic        bus_busy_reg;                      // Start seen, no stop yet

    // Sequencer
    i2cmac_state_t state_reg;                       // Master sequencer state
    logic [7:0]  brg_reg;                           // baud_counter
    logic [7:0]  shift_reg;                         // Transmit shifter
    logic [3:0]  bit_reg;                           // Bits left in byte
    logic        sda_drv_reg;                       // Pulling SDA low
    logic        scl_drv_reg;                       // Pulling SCL low
    logic        brg_zero;                          // Counter timed out

    // Slave receive path for wake from sleep
    logic [7:0]  rx_shift_reg;                      // Received bits
    logic [3:0]  rx_cnt_reg;                        // Bits received
    logic        rx_addr_phase_reg;                 // Next byte is address

    // Bus access decode
    logic        wr_acc;                            // APB write access
    logic        buf_wr;                            // Software writes buffer
    logic        busy;                              // Master sequence active
    logic        collide;                           // Collision this cycle
    logic        cond_done;                         // Sequence completed

    assign sda       = sda_sync_reg[1];
    assign scl       = scl_sync_reg[1];
    assign start_det = scl && scl_prev_reg && sda_prev_reg && !sda;
    assign stop_det  = scl && scl_prev_reg && !sda_prev_reg && sda;
    assign wr_acc    = PSEL && PENABLE && PWRITE;
    assign buf_wr    = wr_acc && (PADDR == OFS_BUFFER);
    assign busy      = (state_reg != I2CMAC_IDLE);
    assign brg_zero  = (brg_reg == 8'h00);

    // Pin sampling; the first stage feeds only the second
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sda_sync_reg <= 2'h3;
            scl_sync_reg <= 2'h3;
            sda_prev_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
            scl_sync_reg <= {scl_sync_reg[0], SCL_IN};
            sda_prev_reg <= sda;
            scl_prev_reg <= scl;
        end
    end

    // Collision detection per state
    always_comb begin
        collide   = 1'b0;
        cond_done = 1'b0;
        case (state_reg)
            I2CMAC_ST_WAIT:  collide = sda && !scl;
            I2CMAC_RS_SCL:   collide = scl && !sda;
            I2CMAC_RS_HIGH:  collide = !scl && sda;
            I2CMAC_SP_SCL:   collide = !scl_prev_reg && 1'b0;
            I2CMAC_SP_HIGH:  collide = !scl || (brg_zero && !sda);
            I2CMAC_AK_HIGH:  collide = scl && !sda_drv_reg && !sda;
            I2CMAC_TX_HIGH:  collide = scl && !sda_drv_reg && !sda;
            default:         collide = 1'b0;
        endcase
        case (state_reg)
            I2CMAC_ST_HOLD, I2CMAC_RS_HOLD: cond_done = brg_zero;
            I2CMAC_AK_HIGH, I2CMAC_SP_HIGH: cond_done = brg_zero && !collide;
            I2CMAC_TX_HIGH:                 cond_done = brg_zero && !collide && bit_reg == 4'h0;
            default:                        cond_done = 1'b0;
        endcase
    end

    // Master sequencer with baud counter and line drivers
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg   <= I2CMAC_IDLE;
            brg_reg     <= 8'h00;
            shift_reg   <= 8'h00;
            bit_reg     <= 4'h0;
            sda_drv_reg <= 1'b0;
            scl_drv_reg <= 1'b0;
        end else if (!ctrl_reg[CTRL_EN] || collide) begin
            state_reg   <= I2CMAC_IDLE;
            brg_reg     <= 8'h00;
            sda_drv_reg <= 1'b0;
            scl_drv_reg <= 1'b0;
        end else begin
            if (!brg_zero) begin
                brg_reg <= brg_reg - 8'h01;
            end
            case (state_reg)
                I2CMAC_IDLE: begin
                    if (con2_reg[CON2_SEN] && sda && scl) begin
                        state_reg <= I2CMAC_ST_WAIT;
                        brg_reg   <= reload_reg;
                    end else if (con2_reg[CON2_RSEN]) begin
                        sda_drv_reg <= 1'b0;
                        state_reg   <= I2CMAC_RS_SDA;
                        brg_reg     <= reload_reg;
                    end else if (con2_reg[CON2_PEN]) begin
                        sda_drv_reg <= 1'b1;
                        state_reg   <= I2CMAC_SP_LOW;
                        brg_reg     <= reload_reg;
                    end else if (con2_reg[CON2_ACKEN]) begin
                        scl_drv_reg <= 1'b1;
                        sda_drv_reg <= !con2_reg[CON2_ACKDT];
                        state_reg   <= I2CMAC_AK_LOW;
                        brg_reg     <= reload_reg;
                    end else if (buf_wr) begin
                        shift_reg   <= PWDATA[7:0];
                        bit_reg     <= 4'h8;
                        scl_drv_reg <= 1'b1;
                        state_reg   <= I2CMAC_TX_LOW;
                        brg_reg     <= reload_reg;
                    end
                end
                I2CMAC_ST_WAIT: begin
                    if (!sda || brg_zero) begin
                        sda_drv_reg <= 1'b1;
                        brg_reg     <= reload_reg;
                        state_reg   <= I2CMAC_ST_HOLD;
                    end
                end
                I2CMAC_ST_HOLD: begin
                    if (brg_zero) begin
                        scl_drv_reg <= 1'b1;
                        state_reg   <= I2CMAC_IDLE;
                    end
                end
                I2CMAC_RS_SDA: begin
                    if (sda && brg_zero) begin
                        scl_drv_reg <= 1'b0;
                        state_reg   <= I2CMAC_RS_SCL;
                    end
                end
                I2CMAC_RS_SCL: begin
                    if (scl) begin
                        brg_reg   <= reload_reg;
                        state_reg <= I2CMAC_RS_HIGH;
                    end
                end
                I2CMAC_RS_HIGH: begin
                    if (!sda || brg_zero) begin
                        sda_drv_reg <= 1'b1;
                        brg_reg     <= reload_reg;
                        state_reg   <= I2CMAC_RS_HOLD;
                    end
                end
                I2CMAC_RS_HOLD: begin
                    if (brg_zero) begin
                        scl_drv_reg <= 1'b1;
                        state_reg   <= I2CMAC_IDLE;
                    end
                end
                I2CMAC_SP_LOW: begin
                    if (!sda && brg_zero) begin
                        scl_drv_reg <= 1'b0;
                        state_reg   <= I2CMAC_SP_SCL;
                    end
                end
                I2CMAC_SP_SCL: begin
                    if (scl) begin
                        brg_reg     <= reload_reg;
                        sda_drv_reg <= 1'b0;
                        state_reg   <= I2CMAC_SP_HIGH;
                    end
                end
                I2CMAC_SP_HIGH: begin
                    if (brg_zero) begin
                        state_reg <= I2CMAC_IDLE;
                    end
                end
                I2CMAC_AK_LOW, I2CMAC_TX_LOW: begin
                    if (brg_zero) begin
                        scl_drv_reg <= 1'b0;
                        brg_reg     <= reload_reg;
                        if (state_reg == I2CMAC_TX_LOW) begin
                            sda_drv_reg <= (bit_reg == 4'h0) ? 1'b0 : !shift_reg[7];
                            state_reg   <= I2CMAC_TX_HIGH;
                        end else begin
                            state_reg   <= I2CMAC_AK_HIGH;
                        end
                    end
                end
                I2CMAC_AK_HIGH: begin
                    if (brg_zero && scl) begin
                        scl_drv_reg <= 1'b1;
                        state_reg   <= I2CMAC_IDLE;
                    end
                end
                I2CMAC_TX_HIGH: begin
                    if (brg_zero && scl) begin
                        scl_drv_reg <= 1'b1;
                        brg_reg     <= reload_reg;
                        if (bit_reg == 4'h0) begin
                            state_reg <= I2CMAC_IDLE;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            bit_reg   <= bit_reg - 4'h1;
                            state_reg <= I2CMAC_TX_LOW;
                        end
                    end
                end
                default: state_reg <= I2CMAC_IDLE;
            endcase
        end
    end

    // Control, reload, slave address and control_register_two
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_reg     <= 4'h0;
            con2_reg     <= 6'h00;
            reload_reg   <= RST_RELOAD;
            slv_addr_reg <= RST_SLV_ADDR;
        end else begin
            if (wr_acc && PADDR == OFS_CTRL) begin
                ctrl_reg <= PWDATA[3:0];
            end
            if (wr_acc && PADDR == OFS_RELOAD) begin
                reload_reg <= PWDATA[7:0];
            end
            if (wr_acc && PADDR == OFS_SLV_ADDR) begin
                slv_addr_reg <= PWDATA[6:0];
            end
            if (!ctrl_reg[CTRL_EN] || collide) begin
                con2_reg[4:0] <= 5'h00;
            end else if (wr_acc && PADDR == OFS_CON2 && !busy) begin
                con2_reg <= PWDATA[5:0];
            end else if (cond_done) begin
                con2_reg[4:0] <= 5'h00;
            end else if (state_reg == I2CMAC_IDLE && con2_reg[CON2_SEN] && !(sda && scl)) begin
                con2_reg[CON2_SEN] <= 1'b0;
            end
        end
    end

    // Buffer and buffer_full_flag
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            buf_reg <= 8'h00;
            bf_reg  <= 1'b0;
        end else if (collide && state_reg == I2CMAC_TX_HIGH) begin
            bf_reg <= 1'b0;
        end else if (buf_wr && !busy) begin
            buf_reg <= PWDATA[7:0];
            bf_reg  <= 1'b1;
        end else if (cond_done && state_reg == I2CMAC_TX_HIGH) begin
            bf_reg <= 1'b0;
        end
    end

    // Bus start and stop watcher
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_seen_reg   <= 1'b0;
            p_seen_reg   <= 1'b0;
            bus_busy_reg <= 1'b0;
        end else if (!ctrl_reg[CTRL_EN]) begin
            s_seen_reg   <= 1'b0;
            p_seen_reg   <= 1'b0;
            bus_busy_reg <= 1'b0;
        end else if (start_det) begin
            s_seen_reg   <= 1'b1;
            p_seen_reg   <= 1'b0;
            bus_busy_reg <= 1'b1;
        end else if (stop_det) begin
            s_seen_reg   <= 1'b0;
            p_seen_reg   <= 1'b1;
            bus_busy_reg <= 1'b0;
        end
    end

    // Slave receive path, runs in sleep too
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_shift_reg      <= 8'h00;
            rx_cnt_reg        <= 4'h0;
            rx_addr_phase_reg <= 1'b0;
        end else if (start_det) begin
            rx_cnt_reg        <= 4'h0;
            rx_addr_phase_reg <= 1'b1;
        end else if (scl && !scl_prev_reg) begin
            if (rx_cnt_reg == 4'h8) begin
                rx_cnt_reg        <= 4'h0;                                // Ack clock
                rx_addr_phase_reg <= 1'b0;
            end else begin
                rx_shift_reg <= {rx_shift_reg[6:0], sda};
                rx_cnt_reg   <= rx_cnt_reg + 4'h1;
            end
        end
    end

    // Sticky flags; hardware set wins over a software clear
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_reg <= 4'h0;
        end else begin
            if (wr_acc && PADDR == OFS_FLAGS) begin
                flags_reg <= flags_reg & ~PWDATA[3:0];
            end
            if (stop_det && bus_busy_reg && ctrl_reg[CTRL_EN]) begin
                flags_reg[FLG_PIF] <= 1'b1;
            end
            if (cond_done) begin
                flags_reg[FLG_PIF] <= 1'b1;
            end
            if (collide || (state_reg == I2CMAC_IDLE && con2_reg[CON2_SEN]
                            && !(sda && scl) && ctrl_reg[CTRL_EN])) begin
                flags_reg[FLG_BCL] <= 1'b1;
            end
            if (buf_wr && busy) begin
                flags_reg[FLG_WRITE_COLLISION_FLAG] <= 1'b1;
            end
            if (ctrl_reg[CTRL_EN] && ctrl_reg[CTRL_SLP] && rx_cnt_reg == 4'h7
                && scl && !scl_prev_reg
                && (!rx_addr_phase_reg || rx_shift_reg[6:0] == slv_addr_reg)) begin
                flags_reg[FLG_WAKE] <= 1'b1;
            end
        end
    end

    // APB slave: zero wait, unmapped reads zero with error
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            if (PSEL && !PENABLE) begin
                case (PADDR)
                    OFS_CTRL:     PRDATA <= {28'h0, ctrl_reg};
                    OFS_CON2:     PRDATA <= {26'h0, con2_reg};
                    OFS_STATUS:   PRDATA <= {27'h0, p_seen_reg, s_seen_reg, busy, 1'b0, bf_reg};
                    OFS_FLAGS:    PRDATA <= {28'h0, flags_reg};
                    OFS_RELOAD:   PRDATA <= {24'h0, reload_reg};
                    OFS_BUFFER:   PRDATA <= {24'h0, buf_reg};
                    OFS_SLV_ADDR: PRDATA <= {25'h0, slv_addr_reg};
                    default:      PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    // Pin drivers and interrupt outputs
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SDA_OUT <= 1'b0;
            SDA_OE  <= 1'b0;
            SCL_OUT <= 1'b0;
            SCL_OE  <= 1'b0;
            IRQ     <= 1'b0;
            WAKE    <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
            SDA_OE  <= sda_drv_reg;
            SCL_OUT <= 1'b0;
            SCL_OE  <= scl_drv_reg;
            IRQ     <= (flags_reg[FLG_PIF] && ctrl_reg[CTRL_PIE])
                    || (flags_reg[FLG_BCL] && ctrl_reg[CTRL_BIE]);
            WAKE    <= flags_reg[FLG_WAKE] && ctrl_reg[CTRL_PIE];
        end
    end
endmodule

// File: i2cmac_top_tb.sv
// Self-checking bench for the collision block against a foreign bus party.
// Assumes the bus model and the bound checker are compiled before it.
`timescale 1ns/10ps
module i2cmac_top_tb;
    import i2cmac_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, lerr;
    logic        sda, scl, sda_oe, scl_oe, irq, hold_sda, frame, sda_out, scl_out, wake;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    int          error_cnt, check_count;
    i2cmac_top DUT (.SYS_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_IN(scl),
        .SCL_OUT(scl_out), .SCL_OE(scl_oe), .IRQ(irq), .WAKE(wake));
    i2cmac_bus_model u_bus (.sda_oe(sda_oe), .scl_oe(scl_oe), .hold_sda(hold_sda),
        .frame(frame), .sda(sda), .scl(scl));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // One bus transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata; lerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wt(ref logic s);
        for (int i = 0; i < 600 && s !== 1'b1; i++) @(posedge clk);
        // A wait that runs out counts as a mismatch
        if (s !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t: wait timed out", $time);
        end
    endtask
    task automatic t_regs;
        apb(0, OFS_RELOAD, 0); chk(r, {24'h0, RST_RELOAD});
        apb(0, 8'h40, 0); chk(lerr, 1); chk(r, 0);
    endtask
    // Foreign frame: stop on a busy bus, then disable clears seen bits
    task automatic t_frame;
        apb(1, OFS_CTRL, 32'h3); frame <= 1'b1;
        repeat (80) @(posedge clk);
        frame <= 1'b0;
        apb(0, OFS_STATUS, 0); chk(r[STAT_P], 1);
        apb(0, OFS_FLAGS, 0); chk(r[FLG_PIF], 1);
        #1 chk(irq, 1);
        chk({sda_out, scl_out, wake}, 0);
        apb(1, OFS_CTRL, 0); apb(0, OFS_STATUS, 0); chk(r[4:3], 0);
    endtask
    // Start asked for while data line is stuck low
    task automatic t_abort;
        apb(1, OFS_CTRL, 32'h5); apb(1, OFS_FLAGS, 32'hF); hold_sda <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1, OFS_CON2, 32'h1); wt(irq);
        apb(0, OFS_FLAGS, 0); chk(r[FLG_BCL], 1);
        apb(0, OFS_CON2, 0); chk(r[CON2_SEN], 0);
        #1 chk(sda_oe, 0);
        hold_sda <= 1'b0; apb(1, OFS_FLAGS, 32'h2); @(posedge clk);
        #1 chk(irq, 0);
    endtask
    // Start, buffer write during Stop, then lost arbitration on a one
    task automatic t_tx;
        apb(1, OFS_RELOAD, 32'h9); apb(1, OFS_CON2, 32'h1); wt(scl_oe);
        #1 chk(sda_oe, 1);
        apb(1, OFS_CON2, 32'h4); apb(1, OFS_BUFFER, 32'h55);
        apb(0, OFS_FLAGS, 0); chk(r[FLG_WRITE_COLLISION_FLAG], 1);
        repeat (100) @(posedge clk);
        apb(1, OFS_FLAGS, 32'hF); apb(1, OFS_CON2, 32'h1); wt(scl_oe);
        hold_sda <= 1'b1; apb(1, OFS_BUFFER, 32'hFF); wt(irq);
        apb(0, OFS_FLAGS, 0); chk(r[FLG_BCL], 1);
        apb(0, OFS_STATUS, 0); chk(r[STAT_BF], 0);
        #1 chk({sda_oe, scl_oe}, 0);
        apb(1, OFS_FLAGS, 32'hD); hold_sda <= 1'b0; repeat (10) @(posedge clk);
        apb(0, OFS_FLAGS, 0); chk(r[FLG_PIF], 1);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        rst_n = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; hold_sda = 1'b0; frame = 1'b0; error_cnt = 0; check_count = 0;
        #1 rst_n = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs; t_frame; t_abort; t_tx;
        give_verdict;
    end
    initial begin
        #200000;
        error_cnt++;
        give_verdict;
    end
endmodule
